// file: logic/hbpwm_pkg.sv
// Package: register map, field layout and constants for the half-bridge PWM unit
package hbpwm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] master_control_zero_off = 8'h00;
  localparam logic [7:0] timer_control_zero_off = 8'h04;
  localparam logic [7:0] period_reload_value_off = 8'h08;
  localparam logic [7:0] compare_zero_value_off = 8'h0c;
  localparam logic [7:0] repetition_count_off = 8'h10;
  localparam logic [7:0] deadtime_cfg_off = 8'h14;
  localparam logic [7:0] timer_irq_dma_enable_off = 8'h18;
  localparam logic [7:0] channel_output_enable_off = 8'h1c;
  localparam logic [7:0] status_off = 8'h20;
  localparam logic [7:0] counter_off = 8'h24;
  localparam logic [7:0] software_update_off = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int counter_run_bit_pos = 0;
  localparam int continuous_run_select_pos = 0;
  localparam int shadow_enable_pos = 1;
  localparam int update_on_counter_reset_pos = 2;
  localparam int update_on_repetition_pos = 3;
  localparam int deadtime_insert_enable_pos = 4;
  localparam int out_a_set_on_period_pos = 5;
  localparam int out_a_clear_on_compare_zero_pos = 6;
  localparam int rising_deadtime_lsb = 0;
  localparam int falling_deadtime_lsb = 16;
  localparam int repetition_irq_enable_pos = 0;
  localparam int output_a_enable_pos = 0;
  localparam int output_b_enable_pos = 1;
  localparam int software_update_request_pos = 0;
  localparam int repetition_flag_pos = 0;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int cnt_w = 16;
  localparam int rep_w = 8;
  localparam int dt_w = 9;
  localparam logic [15:0] period_reset = 16'hffff;
  localparam logic [15:0] compare_reset = 16'h0000;
  localparam logic [6:0] ctl_reset = 7'h01;
  localparam logic [7:0] dt_tick_div = 8'h01;

  // AXI4-Lite responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Dead-time phase of the complementary pair
  typedef enum logic [1:0] {dt_idle, dt_rise, dt_fall} dt_state_t;

  // Outputs toward the gate drivers
  typedef struct packed {
    logic a;
    logic a_oe_n;
    logic b;
    logic b_oe_n;
  } gate_out_t;

endpackage : hbpwm_pkg

// file: logic/hbpwm_top.sv
// Module: half-bridge variable-frequency PWM timer with AXI4-Lite registers
module hbpwm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output hbpwm_pkg::gate_out_t gate,
  output logic timer_irq_line_one
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic run_q;
  logic [6:0] ctl_q;
  logic [15:0] per_sh_q, per_act_q, cmp_sh_q, cmp_act_q, cnt_q;
  logic [7:0] rep_q, rep_cnt_q;
  logic [8:0] dtr_q, dtf_q, dt_cnt_q;
  logic irq_en_q, rep_flag_q;
  logic [1:0] oen_q;
  logic a_q, b_q, a_pre_q, b_pre_q;
  logic [7:0] tick_cnt_q;
  hbpwm_pkg::dt_state_t dt_q;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // Byte-lane merge of a written word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Known register offset
  function automatic logic mapped(input logic [7:0] a);
    return a <= hbpwm_pkg::software_update_off && a[1:0] == 2'h0;
  endfunction : mapped

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [7:0] wa = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_held_q ? wstrb_q : s_axi_wstrb;
  wire have_aw = aw_held_q || s_axi_awvalid;
  wire have_w = w_held_q || s_axi_wvalid;
  wire wr_go = have_aw && have_w && !bvalid_q;
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write strobes per register
  wire wr_mc = wr_go && wa == hbpwm_pkg::master_control_zero_off;
  wire wr_ctl = wr_go && wa == hbpwm_pkg::timer_control_zero_off;
  wire wr_per = wr_go && wa == hbpwm_pkg::period_reload_value_off;
  wire wr_cmp = wr_go && wa == hbpwm_pkg::compare_zero_value_off;
  wire wr_rep = wr_go && wa == hbpwm_pkg::repetition_count_off;
  wire wr_dt = wr_go && wa == hbpwm_pkg::deadtime_cfg_off;
  wire wr_ie = wr_go && wa == hbpwm_pkg::timer_irq_dma_enable_off;
  wire wr_oe = wr_go && wa == hbpwm_pkg::channel_output_enable_off;
  wire wr_st = wr_go && wa == hbpwm_pkg::status_off;
  wire wr_su = wr_go && wa == hbpwm_pkg::software_update_off;
  wire [31:0] per_m = merge({16'h0000, per_sh_q}, wd, ws);
  wire [31:0] cmp_m = merge({16'h0000, cmp_sh_q}, wd, ws);
  wire [31:0] dt_m = merge({7'h00, dtf_q, 7'h00, dtr_q}, wd, ws);
  wire sw_update = wr_su && ws[0] && wd[hbpwm_pkg::software_update_request_pos];

  // Hold address and data until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= hbpwm_pkg::resp_okay;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) wdata_q <= s_axi_wdata;
      if (w_take) wstrb_q <= s_axi_wstrb;
      aw_held_q <= wr_go ? 1'b0 : (aw_held_q || aw_take);
      w_held_q <= wr_go ? 1'b0 : (w_held_q || w_take);
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(wa) ? hbpwm_pkg::resp_okay : hbpwm_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_mux =
    ra == hbpwm_pkg::master_control_zero_off ? {31'h0, run_q} :
    ra == hbpwm_pkg::timer_control_zero_off ? {25'h0, ctl_q} :
    ra == hbpwm_pkg::period_reload_value_off ? {16'h0, per_sh_q} :
    ra == hbpwm_pkg::compare_zero_value_off ? {16'h0, cmp_sh_q} :
    ra == hbpwm_pkg::repetition_count_off ? {24'h0, rep_q} :
    ra == hbpwm_pkg::deadtime_cfg_off ? {7'h0, dtf_q, 7'h0, dtr_q} :
    ra == hbpwm_pkg::timer_irq_dma_enable_off ? {31'h0, irq_en_q} :
    ra == hbpwm_pkg::channel_output_enable_off ? {30'h0, oen_q} :
    ra == hbpwm_pkg::status_off ? {31'h0, rep_flag_q} :
    ra == hbpwm_pkg::counter_off ? {16'h0, cnt_q} : 32'h00000000;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= hbpwm_pkg::resp_okay;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= mapped(ra) ? hbpwm_pkg::resp_okay : hbpwm_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter, events and shadow transfer
  // ----------------------------------------------------------------
  wire shadow_on = ctl_q[hbpwm_pkg::shadow_enable_pos];
  wire per_evt = run_q && ctl_q[hbpwm_pkg::continuous_run_select_pos]
                 && cnt_q >= per_act_q;
  wire cmp_evt = run_q && cnt_q == cmp_act_q;
  wire rep_evt = per_evt && rep_cnt_q == 8'h00;
  wire upd_evt = sw_update
    || (per_evt && ctl_q[hbpwm_pkg::update_on_counter_reset_pos])
    || (rep_evt && ctl_q[hbpwm_pkg::update_on_repetition_pos]);

  // Config registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      ctl_q <= hbpwm_pkg::ctl_reset;
      rep_q <= 8'h00;
      dtr_q <= 9'h000;
      dtf_q <= 9'h000;
      irq_en_q <= 1'b0;
      oen_q <= 2'h0;
    end else begin
      if (wr_mc && ws[0]) run_q <= wd[hbpwm_pkg::counter_run_bit_pos];
      if (wr_ctl && ws[0]) ctl_q <= wd[6:0];
      if (wr_rep && ws[0]) rep_q <= wd[7:0];
      if (wr_dt) begin
        dtr_q <= dt_m[hbpwm_pkg::rising_deadtime_lsb +: 9];
        dtf_q <= dt_m[hbpwm_pkg::falling_deadtime_lsb +: 9];
      end
      if (wr_ie && ws[0]) irq_en_q <= wd[hbpwm_pkg::repetition_irq_enable_pos];
      if (wr_oe && ws[0]) oen_q <= wd[1:0];
    end
  end

  // Shadow and active period / compare pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_sh_q <= hbpwm_pkg::period_reset;
      cmp_sh_q <= hbpwm_pkg::compare_reset;
      per_act_q <= hbpwm_pkg::period_reset;
      cmp_act_q <= hbpwm_pkg::compare_reset;
    end else begin
      if (wr_per) per_sh_q <= per_m[15:0];
      if (wr_cmp) cmp_sh_q <= cmp_m[15:0];
      if (!shadow_on) begin
        if (wr_per) per_act_q <= per_m[15:0];
        if (wr_cmp) cmp_act_q <= cmp_m[15:0];
      end else if (upd_evt) begin
        per_act_q <= per_sh_q;
        cmp_act_q <= cmp_sh_q;
      end
    end
  end

  // Up-counter, repetition counter and sticky repetition flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
      rep_cnt_q <= 8'h00;
      rep_flag_q <= 1'b0;
    end else begin
      if (per_evt) cnt_q <= 16'h0000;
      else if (run_q) cnt_q <= cnt_q + 16'h0001;
      if (rep_evt) rep_cnt_q <= rep_q;
      else if (per_evt) rep_cnt_q <= rep_cnt_q - 8'h01;
      else if (!run_q) rep_cnt_q <= rep_q;
      // Set beats a clear written in the same cycle
      if (rep_evt) rep_flag_q <= 1'b1;
      else if (wr_st && ws[0] && wd[hbpwm_pkg::repetition_flag_pos]) rep_flag_q <= 1'b0;
    end
  end

  assign timer_irq_line_one = rep_flag_q && irq_en_q;

  // ----------------------------------------------------------------
  // Output A and dead-time generator for B
  // ----------------------------------------------------------------
  wire tick = tick_cnt_q == hbpwm_pkg::dt_tick_div - 8'h01;
  wire dt_on = ctl_q[hbpwm_pkg::deadtime_insert_enable_pos];

  // Output A set/reset crossbar, set has priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_pre_q <= 1'b0;
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
      if (per_evt && ctl_q[hbpwm_pkg::out_a_set_on_period_pos]) a_pre_q <= 1'b1;
      else if (cmp_evt && ctl_q[hbpwm_pkg::out_a_clear_on_compare_zero_pos])
        a_pre_q <= 1'b0;
    end
  end

  // With dead-time on, complementary pair with both legs low in each dead-time; with it off, A follows a_pre_q and B is held low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      b_pre_q <= 1'b1;
      dt_cnt_q <= 9'h000;
      dt_q <= hbpwm_pkg::dt_idle;
    end else if (!dt_on) begin
      a_q <= a_pre_q;
      b_q <= 1'b0;
      b_pre_q <= !a_pre_q;
      dt_q <= hbpwm_pkg::dt_idle;
    end else begin
      case (dt_q)
        hbpwm_pkg::dt_idle: begin
          if (a_pre_q != a_q || (!a_pre_q && b_pre_q != b_q) || a_pre_q == b_q) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            // Entry edge is the first tick, so the gap equals the value
            dt_cnt_q <= 9'h001;
            dt_q <= a_pre_q ? hbpwm_pkg::dt_rise : hbpwm_pkg::dt_fall;
          end
        end
        hbpwm_pkg::dt_rise: begin
          if (!a_pre_q) dt_q <= hbpwm_pkg::dt_fall;
          else if (dt_cnt_q >= dtr_q) begin
            a_q <= 1'b1;
            dt_q <= hbpwm_pkg::dt_idle;
          end else if (tick) dt_cnt_q <= dt_cnt_q + 9'h001;
        end
        hbpwm_pkg::dt_fall: begin
          if (a_pre_q) dt_q <= hbpwm_pkg::dt_rise;
          else if (dt_cnt_q >= dtf_q) begin
            b_q <= 1'b1;
            dt_q <= hbpwm_pkg::dt_idle;
          end else if (tick) dt_cnt_q <= dt_cnt_q + 9'h001;
        end
        default: dt_q <= hbpwm_pkg::dt_idle;
      endcase
    end
  end

  // Pin drive gated by the channel output enables
  assign gate.a = a_q;
  assign gate.b = b_q;
  assign gate.a_oe_n = !oen_q[hbpwm_pkg::output_a_enable_pos];
  assign gate.b_oe_n = !oen_q[hbpwm_pkg::output_b_enable_pos];

endmodule : hbpwm_top

// file: testbench/gate_driver_model.sv
// Gate driver model: pin levels seen by the power stage
module gate_driver_model (
  input wire hbpwm_pkg::gate_out_t gate,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released pins fall to the driver's pull-down
  assign pin_a = gate.a_oe_n ? 1'h0 : gate.a;
  assign pin_b = gate.b_oe_n ? 1'h0 : gate.b;
endmodule : gate_driver_model

// file: testbench/hbpwm_top_asserts.sv
// Checker: bus handshake and gate output properties of the PWM timer
module hbpwm_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire hbpwm_pkg::gate_out_t gate,
  input wire logic timer_irq_line_one
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Legs of the half-bridge never conduct together
  property p_no_overlap; !(gate.a && gate.b); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both legs high");
  // Interrupt level only drops after a register write
  property p_irq_hold;
    timer_irq_line_one && !s_axi_awvalid && !s_axi_wvalid |=> timer_irq_line_one;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");
  // Responses stand until taken
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response withdrawn");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data withdrawn");
  // New requests refused while a response waits
  property p_aw_refuse; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken during response");
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken during response");
  // Read answer one cycle after address, write response gone after handshake
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("late read answer");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");
endmodule : hbpwm_top_asserts

bind hbpwm_top hbpwm_top_asserts hbpwm_top_asserts_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .gate, .timer_irq_line_one);

// file: testbench/variable_frequency_halfbridge_pwm_tb_top.sv
// Testbench: register model, waveform timing and event spacing checks
module variable_frequency_halfbridge_pwm_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, irq, pin_a, pin_b, pa_q, iq_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  hbpwm_pkg::gate_out_t gate;
  int mismatches, checks_done, cyc, t0, t1, t2, p, gap, last_gap;
  logic [31:0] m [logic [7:0]];

  hbpwm_top hbpwm_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate, .timer_irq_line_one(irq));
  gate_driver_model gate_driver_model_i (.gate, .pin_a, .pin_b);

  // Clock, cycle count and edge history
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    pa_q <= pin_a;
    iq_q <= irq;
    // Length of the current and of the last both-legs-low gap
    gap <= (pin_a || pin_b) ? 0 : gap + 1;
    if ((pin_a || pin_b) && gap != 0) last_gap <= gap;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h0;
    n = 0;
    while (!b && n < 50) begin
      @(negedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      n++;
    end
    s_axi_bready <= 1'h0;
    chk(b, 1'h1);
    chk(rs, er);
    if (er == hbpwm_pkg::resp_okay) m[a] = d;
  endtask : wr

  // Read, compared with the model when asked
  task automatic rdc(input logic [7:0] a, input logic [1:0] er, input logic cmp);
    logic ar, r;
    logic [1:0] rs;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    ar = 1'h1;
    r = 1'h0;
    n = 0;
    while (!r && n < 50) begin
      @(negedge aclk);
      ar = ar && !s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      s_axi_arvalid <= ar;
      n++;
    end
    s_axi_rready <= 1'h0;
    chk(r, 1'h1);
    chk(rs, er);
    if (cmp) chk(rd, m.exists(a) ? m[a] : 32'h0);
  endtask : rdc

  // Wait for a rising edge of output A or of the interrupt
  task automatic rise(input logic on_irq, output int t);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(on_irq ? irq && !iq_q : pin_a && !pa_q) && n < 2000);
    t = cyc;
    if (n >= 2000) chk(32'h0, 32'h1);
  endtask : rise

  // Leg levels early in the high phase and about eight cycles after B rises in the low phase
  // Gaps: rising 2 and falling 3 ticks, as written to the dead-time register
  task automatic legs(input int c);
    chk(gap, 2);
    repeat (3) @(negedge aclk);
    chk({pin_a, pin_b}, 2'h2);
    repeat (c + 7) @(negedge aclk);
    chk({pin_a, pin_b}, 2'h1);
    chk(last_gap, 3);
  endtask : legs

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cyc, mismatches, checks_done, gap, last_gap} = 0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h4871));
    for (int i = 0; i < 10; i++) m[8'(i * 4)] = 32'h0;
    m[8'h04] = 32'h1;
    m[8'h08] = 32'hffff;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    chk(gate, 4'h5);
    for (int i = 0; i < 10; i++) rdc(8'(i * 4), hbpwm_pkg::resp_okay, 1'h1);
    rdc(8'h30, hbpwm_pkg::resp_slverr, 1'h1);
    wr(8'h30, 32'h1, hbpwm_pkg::resp_slverr);
    p = 40 + $urandom % 16;
    wr(8'h04, 32'h77, hbpwm_pkg::resp_okay);
    wr(8'h08, p, hbpwm_pkg::resp_okay);
    wr(8'h0c, p / 2, hbpwm_pkg::resp_okay);
    wr(8'h10, 32'h2, hbpwm_pkg::resp_okay);
    wr(8'h14, 32'h30002, hbpwm_pkg::resp_okay);
    wr(8'h18, 32'h1, hbpwm_pkg::resp_okay);
    wr(8'h1c, 32'h3, hbpwm_pkg::resp_okay);
    for (int i = 1; i < 8; i++) rdc(8'(i * 4), hbpwm_pkg::resp_okay, 1'h1);
    wr(8'h28, 32'h1, hbpwm_pkg::resp_okay);
    wr(8'h00, 32'h1, hbpwm_pkg::resp_okay);
    chk({gate.a_oe_n, gate.b_oe_n}, 2'h0);
    rise(1'h0, t0);
    rise(1'h0, t1);
    chk(t1 - t0, p + 1);
    legs(p / 2);
    wr(8'h20, 32'h1, hbpwm_pkg::resp_okay);
    rise(1'h1, t0);
    wr(8'h20, 32'h1, hbpwm_pkg::resp_okay);
    rise(1'h1, t1);
    chk(t1 - t0, 3 * (p + 1));
    wr(8'h18, 32'h0, hbpwm_pkg::resp_okay);
    chk(irq, 1'h0);
    wr(8'h18, 32'h1, hbpwm_pkg::resp_okay);
    rise(1'h0, t0);
    wr(8'h08, p + 10, hbpwm_pkg::resp_okay);
    wr(8'h0c, (p + 10) / 2, hbpwm_pkg::resp_okay);
    rise(1'h0, t1);
    rise(1'h0, t2);
    chk(t1 - t0, p + 1);
    chk(t2 - t1, p + 11);
    legs((p + 10) / 2);
    p = p + 10;
    wr(8'h04, 32'h7b, hbpwm_pkg::resp_okay);
    wr(8'h20, 32'h1, hbpwm_pkg::resp_okay);
    rise(1'h1, t0);
    wr(8'h08, p - 20, hbpwm_pkg::resp_okay);
    wr(8'h0c, (p - 20) / 2, hbpwm_pkg::resp_okay);
    wr(8'h20, 32'h1, hbpwm_pkg::resp_okay);
    rise(1'h1, t1);
    wr(8'h20, 32'h1, hbpwm_pkg::resp_okay);
    rise(1'h1, t2);
    chk(t1 - t0, 3 * (p + 1));
    chk(t2 - t1, 3 * (p - 19));
    wr(8'h1c, 32'h0, hbpwm_pkg::resp_okay);
    chk({gate.a_oe_n, gate.b_oe_n, pin_a, pin_b}, 4'hc);
    wr(8'h00, 32'h0, hbpwm_pkg::resp_okay);
    rdc(8'h24, hbpwm_pkg::resp_okay, 1'h0);
    t0 = rd;
    rdc(8'h24, hbpwm_pkg::resp_okay, 1'h0);
    chk(rd, t0);
    conclude();
  end

  // Watchdog against a hang
  initial begin
    #300000;
    mismatches++;
    conclude();
  end
endmodule : variable_frequency_halfbridge_pwm_tb_top
